// File: hw/rail_cfg_pkg.sv
// Purpose: Shared constants and types for the rail configuration register bank.
// Assumes: Byte-wide registers reached over a two-wire serial management bus.
// Notes: Every offset, mask, reset value and state code lives here.
package rail_cfg_pkg;

    // Register offsets on the serial bus.
    localparam logic [7:0] REG_SWITCH1_REGULATOR_CONFIG = 8'h14;
    localparam logic [7:0] REG_SWITCH2_REGULATOR_CONFIG = 8'h15;
    localparam logic [7:0] REG_RAIL_ENABLE = 8'h16;
    // Unlock register that arms one protected write.
    localparam logic [7:0] REG_PASSWORD = 8'h10;

    // Reset values.
    localparam logic [7:0] SWITCH1_CONFIG_RESET = 8'h26;
    localparam logic [7:0] SWITCH2_CONFIG_RESET = 8'h3f;
    localparam logic [7:0] RAIL_ENABLE_RESET = 8'h00;

    // Writable bits; everything outside a mask is reserved and reads zero.
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h3f;
    localparam logic [7:0] RAIL_ENABLE_WRITE_MASK = 8'h7f;

    // Field positions.
    localparam int CONFIG_MODE_BIT = 5;
    localparam int CONFIG_CODE_MSB = 4;
    localparam int ENABLE_SWITCH1_BIT = 6;
    localparam int ENABLE_SWITCH2_BIT = 5;

    // Width of a voltage code and of a target in millivolts.
    localparam int CODE_WIDTH = 5;
    localparam int MV_WIDTH = 12;

    // Bits per serial byte, counted before the acknowledge slot.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // One rail's configuration as held in its register.
    typedef struct packed {
        logic regulator_mode;
        logic [CODE_WIDTH-1:0] voltage_code;
    } rail_config_t;

    // Serial engine states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_POINTER = 4'h2,
        ST_POINTER_ACK = 4'h6,
        ST_WRITE = 4'h7,
        ST_WRITE_ACK = 4'h5,
        ST_READ = 4'h4,
        ST_READ_ACK = 4'hc
    } bus_state_t;

endpackage : rail_cfg_pkg

// File: hw/voltage_code_table.sv
// Purpose: Translate a five-bit regulator voltage code to a target in millivolts.
// Assumes: Combinational lookup; the caller registers the result.
// Notes: Code zero is 1500 mV and the all-ones code is 3300 mV.
`timescale 1ns/100ps
module voltage_code_table
(
    input wire logic [rail_cfg_pkg::CODE_WIDTH-1:0] code,
    output logic [rail_cfg_pkg::MV_WIDTH-1:0] millivolts
);

    // Fixed table; steps are uneven between 1.9 V and 2.4 V.
    always_comb
    begin
        case (code)
            5'h00: millivolts = 12'h5dc;
            5'h01: millivolts = 12'h60e;
            5'h02: millivolts = 12'h640;
            5'h03: millivolts = 12'h672;
            5'h04: millivolts = 12'h6a4;
            5'h05: millivolts = 12'h6d6;
            5'h06: millivolts = 12'h708;
            5'h07: millivolts = 12'h73a;
            5'h08: millivolts = 12'h76c;
            5'h09: millivolts = 12'h7d0;
            5'h0a: millivolts = 12'h834;
            5'h0b: millivolts = 12'h898;
            5'h0c: millivolts = 12'h8fc;
            5'h0d: millivolts = 12'h960;
            5'h0e: millivolts = 12'h992;
            5'h0f: millivolts = 12'h9c4;
            5'h10: millivolts = 12'h9f6;
            5'h11: millivolts = 12'ha28;
            5'h12: millivolts = 12'ha5a;
            5'h13: millivolts = 12'ha8c;
            5'h14: millivolts = 12'habe;
            5'h15: millivolts = 12'haf0;
            5'h16: millivolts = 12'hb22;
            5'h17: millivolts = 12'hb54;
            5'h18: millivolts = 12'hb86;
            5'h19: millivolts = 12'hbb8;
            5'h1a: millivolts = 12'hbea;
            5'h1b: millivolts = 12'hc1c;
            5'h1c: millivolts = 12'hc4e;
            5'h1d: millivolts = 12'hc80;
            5'h1e: millivolts = 12'hcb2;
            5'h1f: millivolts = 12'hce4;
            default: millivolts = 12'hce4;
        endcase
    end

endmodule : voltage_code_table

// File: hw/load_switch_regulator_config_regs.sv
// Purpose: Serial-bus register bank for two switch-or-regulator FETs and the rail enable byte.
// Assumes: Bus pins are asynchronous to clk and are sampled through two flip-flops.
// Notes: Writes to the three protected registers need a fresh unlock before each write.
`timescale 1ns/100ps

module load_switch_regulator_config_regs
#(
    parameter logic [6:0] DEVICE_ADDRESS = 7'h48,
    parameter logic [7:0] PASSWORD_KEY = 8'h5a
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic power_enable_pin,
    output logic load_switch_one_on,
    output logic load_switch_two_on,
    output logic switch1_mode_select,
    output logic switch2_mode_select,
    output logic [rail_cfg_pkg::MV_WIDTH-1:0] linear_regulator_three_mv,
    output logic [rail_cfg_pkg::MV_WIDTH-1:0] linear_regulator_four_mv
);

    // Synchroniser stages; the meta stages feed only the sync stages.
    logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev, pwr_meta, pwr_sync;
    logic next_scl_meta, next_scl_sync, next_scl_prev, next_sda_meta, next_sda_sync, next_sda_prev;
    logic next_pwr_meta, next_pwr_sync;

    // Serial engine state.
    rail_cfg_pkg::bus_state_t state, next_state;
    logic [3:0] bit_count, next_bit_count;
    logic [7:0] shifter, next_shifter, pointer, next_pointer;
    logic read_request, next_read_request, unlocked, next_unlocked, next_sda_out, next_sda_oe;

    // Register contents, stored already masked.
    logic [7:0] switch1_regulator_config, switch2_regulator_config, rail_enable;
    logic [7:0] next_switch1_regulator_config, next_switch2_regulator_config, next_rail_enable;

    // Registered outputs toward the analog side.
    logic next_load_switch_one_on, next_load_switch_two_on, next_switch1_mode_select, next_switch2_mode_select;
    logic [rail_cfg_pkg::MV_WIDTH-1:0] next_linear_regulator_three_mv, next_linear_regulator_four_mv;

    // Unpacked views of the two configuration bytes.
    rail_cfg_pkg::rail_config_t rail3_cfg, rail4_cfg;
    logic [rail_cfg_pkg::MV_WIDTH-1:0] rail3_table_mv, rail4_table_mv;

    // Bus events decoded from the synchronised pins.
    logic scl_rise, scl_fall, bus_start, bus_stop;

    assign scl_rise = scl_sync & ~scl_prev;
    assign scl_fall = ~scl_sync & scl_prev;
    assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign bus_stop = scl_sync & scl_prev & ~sda_prev & sda_sync;

    assign rail3_cfg = rail_cfg_pkg::rail_config_t'(switch1_regulator_config[rail_cfg_pkg::CONFIG_MODE_BIT:0]);
    assign rail4_cfg = rail_cfg_pkg::rail_config_t'(switch2_regulator_config[rail_cfg_pkg::CONFIG_MODE_BIT:0]);

    // Read decode; unmapped offsets and the unlock register read as zero.
    function automatic logic [7:0] read_value(input logic [7:0] offset, input logic [7:0] cfg1,
                                              input logic [7:0] cfg2, input logic [7:0] enables);
        case (offset)
            rail_cfg_pkg::REG_SWITCH1_REGULATOR_CONFIG: read_value = cfg1 & rail_cfg_pkg::CONFIG_WRITE_MASK;
            rail_cfg_pkg::REG_SWITCH2_REGULATOR_CONFIG: read_value = cfg2 & rail_cfg_pkg::CONFIG_WRITE_MASK;
            rail_cfg_pkg::REG_RAIL_ENABLE: read_value = enables & rail_cfg_pkg::RAIL_ENABLE_WRITE_MASK;
            default: read_value = 8'h00;
        endcase
    endfunction : read_value

    // True for offsets that only an unlocked write may change.
    function automatic logic is_protected(input logic [7:0] offset);
        is_protected = (offset == rail_cfg_pkg::REG_SWITCH1_REGULATOR_CONFIG) ||
                       (offset == rail_cfg_pkg::REG_SWITCH2_REGULATOR_CONFIG) ||
                       (offset == rail_cfg_pkg::REG_RAIL_ENABLE);
    endfunction : is_protected

    // Both rails share one table shape, so one module is placed twice.
    voltage_code_table rail3_table
    (
        .code(rail3_cfg.voltage_code),
        .millivolts(rail3_table_mv)
    );

    voltage_code_table rail4_table
    (
        .code(rail4_cfg.voltage_code),
        .millivolts(rail4_table_mv)
    );

    // Next values for the synchronisers, the serial engine, the registers and the outputs.
    always_comb
    begin
        next_scl_meta = scl_in;
        next_scl_sync = scl_meta;
        next_scl_prev = scl_sync;
        next_sda_meta = sda_in;
        next_sda_sync = sda_meta;
        next_sda_prev = sda_sync;
        next_pwr_meta = power_enable_pin;
        next_pwr_sync = pwr_meta;
        next_state = state;
        next_bit_count = bit_count;
        next_shifter = shifter;
        next_pointer = pointer;
        next_read_request = read_request;
        next_unlocked = unlocked;
        next_sda_out = 1'b0;
        next_sda_oe = sda_oe;
        next_switch1_regulator_config = switch1_regulator_config;
        next_switch2_regulator_config = switch2_regulator_config;
        next_rail_enable = rail_enable;
        if (bus_start)
        begin
            // A start, repeated or not, always restarts address reception.
            next_state = rail_cfg_pkg::ST_ADDR;
            next_bit_count = 4'h0;
            next_sda_oe = 1'b0;
        end
        else if (bus_stop)
        begin
            // A stop frees the line; the unlock survives so it may precede a new frame.
            next_state = rail_cfg_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end
        else
        begin
            case (state)
                rail_cfg_pkg::ST_IDLE:
                begin
                    // Wait for a start.
                    next_sda_oe = 1'b0;
                end
                rail_cfg_pkg::ST_ADDR, rail_cfg_pkg::ST_POINTER, rail_cfg_pkg::ST_WRITE:
                begin
                    // Bits are taken while the clock rises, most significant first.
                    if (scl_rise)
                    begin
                        next_shifter = {shifter[6:0], sda_sync};
                        next_bit_count = bit_count + 4'h1;
                    end
                    else if (scl_fall && bit_count == rail_cfg_pkg::BITS_PER_BYTE)
                    begin
                        next_bit_count = 4'h0;
                        next_sda_oe = 1'b1;
                        if (state == rail_cfg_pkg::ST_ADDR)
                        begin
                            // Only our own address is acknowledged; others are left alone.
                            if (shifter[7:1] == DEVICE_ADDRESS)
                            begin
                                next_read_request = shifter[0];
                                next_state = rail_cfg_pkg::ST_ADDR_ACK;
                            end
                            else
                            begin
                                next_sda_oe = 1'b0;
                                next_state = rail_cfg_pkg::ST_IDLE;
                            end
                        end
                        else if (state == rail_cfg_pkg::ST_POINTER)
                        begin
                            next_pointer = shifter;
                            next_state = rail_cfg_pkg::ST_POINTER_ACK;
                        end
                        else
                        begin
                            // Every written byte consumes the unlock, accepted or not.
                            next_unlocked = 1'b0;
                            if (pointer == rail_cfg_pkg::REG_PASSWORD)
                            begin
                                next_unlocked = (shifter == PASSWORD_KEY);
                            end
                            else if (is_protected(pointer) && unlocked)
                            begin
                                case (pointer)
                                    rail_cfg_pkg::REG_SWITCH1_REGULATOR_CONFIG:
                                    begin
                                        // Mode and code update; reserved bits stay zero.
                                        next_switch1_regulator_config = shifter & rail_cfg_pkg::CONFIG_WRITE_MASK;
                                    end
                                    rail_cfg_pkg::REG_SWITCH2_REGULATOR_CONFIG:
                                    begin
                                        next_switch2_regulator_config = shifter & rail_cfg_pkg::CONFIG_WRITE_MASK;
                                    end
                                    default:
                                    begin
                                        next_rail_enable = shifter & rail_cfg_pkg::RAIL_ENABLE_WRITE_MASK;
                                    end
                                endcase
                            end
                            // Bursts walk through consecutive offsets.
                            next_pointer = pointer + 8'h01;
                            next_state = rail_cfg_pkg::ST_WRITE_ACK;
                        end
                    end
                end
                rail_cfg_pkg::ST_ADDR_ACK, rail_cfg_pkg::ST_POINTER_ACK, rail_cfg_pkg::ST_WRITE_ACK, rail_cfg_pkg::ST_READ_ACK:
                begin
                    // On a read, a high acknowledge slot from the host ends the transfer.
                    if (state == rail_cfg_pkg::ST_READ_ACK && scl_rise && sda_sync)
                    begin
                        next_state = rail_cfg_pkg::ST_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        next_sda_oe = 1'b0;
                        next_bit_count = 4'h0;
                        if ((state == rail_cfg_pkg::ST_ADDR_ACK && read_request) || state == rail_cfg_pkg::ST_READ_ACK)
                        begin
                            // Load the byte and put its first bit on the line at once.
                            next_shifter = read_value(pointer, switch1_regulator_config, switch2_regulator_config,
                                                      rail_enable);
                            next_sda_oe = ~next_shifter[7];
                            next_pointer = pointer + 8'h01;
                            next_state = rail_cfg_pkg::ST_READ;
                        end
                        else if (state == rail_cfg_pkg::ST_ADDR_ACK)
                        begin
                            next_state = rail_cfg_pkg::ST_POINTER;
                        end
                        else
                        begin
                            next_state = rail_cfg_pkg::ST_WRITE;
                        end
                    end
                end
                rail_cfg_pkg::ST_READ:
                begin
                    // Low bits are driven by enabling the pull-down only.
                    if (scl_rise)
                    begin
                        next_bit_count = bit_count + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_count == rail_cfg_pkg::BITS_PER_BYTE)
                        begin
                            next_sda_oe = 1'b0;
                            next_state = rail_cfg_pkg::ST_READ_ACK;
                        end
                        else
                        begin
                            next_shifter = {shifter[6:0], 1'b0};
                            next_sda_oe = ~shifter[6];
                        end
                    end
                end
                default:
                begin
                    next_state = rail_cfg_pkg::ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
        // The first FET conducts only with its enable bit and the pin both high.
        next_load_switch_one_on = rail_enable[rail_cfg_pkg::ENABLE_SWITCH1_BIT] & pwr_sync;
        next_load_switch_two_on = rail_enable[rail_cfg_pkg::ENABLE_SWITCH2_BIT] & pwr_sync;
        next_switch1_mode_select = rail3_cfg.regulator_mode;
        next_switch2_mode_select = rail4_cfg.regulator_mode;
        // The target is meaningful only in regulator mode, so it reads zero as a switch.
        next_linear_regulator_three_mv = rail3_cfg.regulator_mode ? rail3_table_mv : 12'h000;
        next_linear_regulator_four_mv = rail4_cfg.regulator_mode ? rail4_table_mv : 12'h000;
    end

    // State registers; reset loads the documented power-up contents.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            pwr_meta <= 1'b0;
            pwr_sync <= 1'b0;
            state <= rail_cfg_pkg::ST_IDLE;
            bit_count <= 4'h0;
            shifter <= 8'h00;
            pointer <= 8'h00;
            read_request <= 1'b0;
            unlocked <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            switch1_regulator_config <= rail_cfg_pkg::SWITCH1_CONFIG_RESET;
            switch2_regulator_config <= rail_cfg_pkg::SWITCH2_CONFIG_RESET;
            rail_enable <= rail_cfg_pkg::RAIL_ENABLE_RESET;
            load_switch_one_on <= 1'b0;
            load_switch_two_on <= 1'b0;
            switch1_mode_select <= 1'b0;
            switch2_mode_select <= 1'b0;
            linear_regulator_three_mv <= 12'h000;
            linear_regulator_four_mv <= 12'h000;
        end
        else
        begin
            scl_meta <= next_scl_meta;
            scl_sync <= next_scl_sync;
            scl_prev <= next_scl_prev;
            sda_meta <= next_sda_meta;
            sda_sync <= next_sda_sync;
            sda_prev <= next_sda_prev;
            pwr_meta <= next_pwr_meta;
            pwr_sync <= next_pwr_sync;
            state <= next_state;
            bit_count <= next_bit_count;
            shifter <= next_shifter;
            pointer <= next_pointer;
            read_request <= next_read_request;
            unlocked <= next_unlocked;
            sda_out <= next_sda_out;
            sda_oe <= next_sda_oe;
            switch1_regulator_config <= next_switch1_regulator_config;
            switch2_regulator_config <= next_switch2_regulator_config;
            rail_enable <= next_rail_enable;
            load_switch_one_on <= next_load_switch_one_on;
            load_switch_two_on <= next_load_switch_two_on;
            switch1_mode_select <= next_switch1_mode_select;
            switch2_mode_select <= next_switch2_mode_select;
            linear_regulator_three_mv <= next_linear_regulator_three_mv;
            linear_regulator_four_mv <= next_linear_regulator_four_mv;
        end
    end

endmodule : load_switch_regulator_config_regs

// File: tb/rail_cfg_checker.sv
// Purpose: Port-level assertions for the rail configuration register bank.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Attached to every instance of the bank by the bind below.
`timescale 1ns/100ps
module rail_cfg_checker
(
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_enable_pin,
    input wire logic load_switch_one_on,
    input wire logic load_switch_two_on,
    input wire logic switch1_mode_select,
    input wire logic switch2_mode_select,
    input wire logic [rail_cfg_pkg::MV_WIDTH-1:0] linear_regulator_three_mv,
    input wire logic [rail_cfg_pkg::MV_WIDTH-1:0] linear_regulator_four_mv
);
    // All checks share the system clock and drop out during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Four low samples cover the pin synchroniser, so the rail must be off.
    property p_one_pin; (!power_enable_pin)[*4] |=> !load_switch_one_on; endproperty
    a_one_pin: assert property (p_one_pin) else $error("switch one on with pin low");
    property p_two_pin; (!power_enable_pin)[*4] |=> !load_switch_two_on; endproperty
    a_two_pin: assert property (p_two_pin) else $error("switch two on with pin low");
    property p_one_sw; !switch1_mode_select |-> linear_regulator_three_mv == 12'h000; endproperty
    a_one_sw: assert property (p_one_sw) else $error("target shown in switch mode one");
    property p_two_sw; !switch2_mode_select |-> linear_regulator_four_mv == 12'h000; endproperty
    a_two_sw: assert property (p_two_sw) else $error("target shown in switch mode two");
    property p_one_rng; switch1_mode_select |-> linear_regulator_three_mv inside {[12'h5dc:12'hce4]}; endproperty
    a_one_rng: assert property (p_one_rng) else $error("target one out of table");
    property p_two_rng; switch2_mode_select |-> linear_regulator_four_mv inside {[12'h5dc:12'hce4]}; endproperty
    a_two_rng: assert property (p_two_rng) else $error("target two out of table");
    property p_one_rst; $fell(srst) |-> ##[0:3] (switch1_mode_select && linear_regulator_three_mv == 12'h708); endproperty
    a_one_rst: assert property (p_one_rst) else $error("rail one reset state");
    property p_two_rst; $fell(srst) |-> ##[0:3] (switch2_mode_select && linear_regulator_four_mv == 12'hce4); endproperty
    a_two_rst: assert property (p_two_rst) else $error("rail two reset state");
endmodule : rail_cfg_checker

bind load_switch_regulator_config_regs rail_cfg_checker rail_cfg_checker_inst (.clk(clk), .srst(srst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .power_enable_pin(power_enable_pin),
    .load_switch_one_on(load_switch_one_on), .load_switch_two_on(load_switch_two_on),
    .switch1_mode_select(switch1_mode_select), .switch2_mode_select(switch2_mode_select),
    .linear_regulator_three_mv(linear_regulator_three_mv), .linear_regulator_four_mv(linear_regulator_four_mv));

// File: tb/host_model.sv
// Purpose: Bus master model that reaches the bank's registers.
// Assumes: SDA is open drain; the bench resolves it with a pull-up.
// Notes: SDA only moves two clocks after SCL, so no false start or stop is seen.
`timescale 1ns/100ps
module host_model #(parameter logic [6:0] DEV = 7'h48, parameter logic [7:0] KEY = 8'h5a)
(
    input wire logic clk,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    int nack_cnt = 0; // Address and data bytes the device failed to acknowledge.
    // One phase: move SCL, then SDA, always just after a rising edge.
    task automatic step(input logic c, input logic d);
        scl <= c;
        repeat (2) @(posedge clk);
        sda_low <= d;
        repeat (5) @(posedge clk);
    endtask : step
    // Nine bit slots, MSB first; a released bit reads back the device.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            step(1'b0, !tx[i]);
            step(1'b1, !tx[i]);
            rx[i] = sda;
            step(1'b1, !tx[i]);
        end
    endtask : xfer
    // Byte sent by the host; the ninth slot is left to the device.
    task automatic put(input logic [7:0] b);
        logic [8:0] rx;
        xfer({b, 1'b1}, rx);
        nack_cnt += rx[0];
    endtask : put
    // Start, also used as repeated start.
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : start
    // Every register is one byte per access.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        start();
        put({DEV, 1'b0});
        put(a);
        put(d);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : reg_write
    // Single-byte read ended by a host not-acknowledge.
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] rx;
        start();
        put({DEV, 1'b0});
        put(a);
        start();
        put({DEV, 1'b1});
        xfer(9'h1ff, rx);
        d = rx[8:1];
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : reg_read
    // Arms one protected write, in its own transaction.
    task automatic unlock();
        reg_write(rail_cfg_pkg::REG_PASSWORD, KEY);
    endtask : unlock
endmodule : host_model

// File: tb/load_switch_regulator_config_regs_test.sv
// Purpose: Self-checking bench for the rail configuration register bank.
// Assumes: The host model drives the bus; the bench drives the power enable pin.
// Notes: Every scenario judges its own results before it returns.
`timescale 1ns/100ps
module load_switch_regulator_config_regs_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic power_enable_pin = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, on1, on2, m1, m2;
    logic [11:0] mv3, mv4;
    wire sda = !(sda_low | sda_oe); // Pulled up unless someone pulls low.
    int error_cnt = 0;
    int checks = 0;
    always #50 clk = !clk;
    load_switch_regulator_config_regs load_switch_regulator_config_regs_inst (.clk(clk), .srst(srst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .power_enable_pin(power_enable_pin),
        .load_switch_one_on(on1), .load_switch_two_on(on2), .switch1_mode_select(m1), .switch2_mode_select(m2),
        .linear_regulator_three_mv(mv3), .linear_regulator_four_mv(mv4));
    host_model host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_model_inst.reg_read(a, d);
        chk("register", {4'h0, d}, {4'h0, e});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.unlock();
        host_model_inst.reg_write(a, d);
    endtask : wr
    task automatic t_reset();
        rd(8'h14, 8'h26);
        rd(8'h15, 8'h3f);
        rd(8'h16, 8'h00);
        chk("mode two", {11'h0, m2}, 12'h001);
        chk("mv three", mv3, 12'h708);
        chk("mv four", mv4, 12'hce4);
        chk("sda out", {11'h0, sda_out}, 12'h000);
    endtask : t_reset
    // A write without the password is ignored; the arm covers only one write.
    task automatic t_lock();
        host_model_inst.reg_write(8'h14, 8'h00);
        rd(8'h14, 8'h26);
        wr(8'h15, 8'hc0);
        host_model_inst.reg_write(8'h15, 8'h3f);
        rd(8'h15, 8'h00);
        chk("mode two", {11'h0, m2}, 12'h000);
    endtask : t_lock
    task automatic t_cfg1();
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h3f);
        chk("mv three", mv3, 12'hce4);
        wr(8'h14, 8'h09);
        chk("mode one", {11'h0, m1}, 12'h000);
        wr(8'h14, 8'h29);
        chk("mv three", mv3, 12'h7d0);
        rd(8'h14, 8'h29);
    endtask : t_cfg1
    task automatic t_enable();
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h7f);
        chk("switch one", {11'h0, on1}, 12'h000);
        power_enable_pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("switch one", {11'h0, on1}, 12'h001);
        chk("switch two", {11'h0, on2}, 12'h001);
        chk("nacks", host_model_inst.nack_cnt[11:0], 12'h000);
    endtask : t_enable
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // Watchdog: the sequence needs about 14000 clocks.
    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        t_reset();
        t_lock();
        t_cfg1();
        t_enable();
        end_of_test();
    end
endmodule : load_switch_regulator_config_regs_test
